// file: dio_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "dio_map.svh"
module dio_bank
  import dio_pkg::*;
#(
  parameter int ERR_W = 32
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire dio_req_t                    req,
  output dio_rsp_t                         rsp,
  input  wire logic                        din_one_pin,
  input  wire dio_func_t                   conn_func_pin,
  input  wire logic [`DIO_STAT_A_W-1:0]    drive_out_a,
  input  wire logic [`DIO_STAT_B_W-1:0]    drive_out_b,
  input  wire logic signed [ERR_W-1:0]     pos_err,
  input  wire logic signed [ERR_W-1:0]     pos_ctrl_in,
  output logic signed [ERR_W-1:0]          pos_ctrl_out,
  output dio_func_t                        eff_func,
  output logic [15:0]                      gain_wait_ms,
  output logic [15:0]                      gain_return_ms
);

  logic [15:0] gain_wait_q;
  logic [15:0] gain_return_q;
  logic [15:0] dead_band_q;
  logic [15:0] soft_a_q;
  logic [15:0] soft_b_q;
  logic [15:0] status_a_q;
  logic [15:0] status_b_q;
  logic [15:0] assign_q;
  dio_rsp_t    rsp_q;
  dio_func_t   eff_q;
  logic        din_one_lvl;
  dio_func_t   conn_lvl;
  logic        wr;
  logic        in_range;
  logic [ERR_W-1:0] err_abs;
  logic        in_band;

  // Assignment code to function bit; probe codes drive no word bit
  function automatic dio_func_t code_to_func(input logic [7:0] code);
    dio_func_t f;
    f = '0;
    unique case (code)
      8'h01, 8'h02, 8'h03, 8'h04,
      8'h05, 8'h06, 8'h07, 8'h08: f.a[code[3:0] - 4'h1] = 1'b1;
      8'h0b:                       f.a[10] = 1'b1;
      8'h0c:                       f.a[11] = 1'b1;
      `DIO_CODE_SERVO_ON:          f.a[12] = 1'b1;
      8'h20:                       f.a[13] = 1'b1;
      8'h21:                       f.a[14] = 1'b1;
      8'h22:                       f.a[15] = 1'b1;
      8'h23:                       f.a[8]  = 1'b1;
      default:
      begin
        if (code[7:4] == 4'h1)
          f.b[code[3:0]] = 1'b1;
      end
    endcase
    return f;
  endfunction : code_to_func

  // Pin level inputs cross into mclk
  dio_pin_sync #(
    .W (33)
  ) u_sync (
    .mclk  (mclk),
    .srst  (srst),
    .pin   ({din_one_pin, conn_func_pin}),
    .level ({din_one_lvl, conn_lvl})
  );

  assign wr       = req.valid && req.write;
  assign in_range = (req.wdata <= `DIO_MAX_SETTING);

  // Wait times; out-of-range values are refused, not clipped
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      gain_wait_q   <= `DIO_RST_GAIN_WAIT;
      gain_return_q <= `DIO_RST_GAIN_RETURN;
    end
    else if (wr && in_range)
    begin
      if (req.index == `DIO_IDX_GAIN_WAIT)
        gain_wait_q <= req.wdata;
      if (req.index == `DIO_IDX_GAIN_RETURN)
        gain_return_q <= req.wdata;
    end
  end

  // Dead band setting
  always_ff @(posedge mclk)
  begin
    if (srst)
      dead_band_q <= `DIO_RST_DEAD_BAND;
    else if (wr && in_range && req.index == `DIO_IDX_DEAD_BAND)
      dead_band_q <= req.wdata;
  end

  // Software control words; reserved bits never stored
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      soft_a_q <= `DIO_RST_SOFT;
      soft_b_q <= `DIO_RST_SOFT;
    end
    else if (wr)
    begin
      if (req.index == `DIO_IDX_SOFT_A)
        soft_a_q <= req.wdata & `DIO_SOFT_A_MASK;
      if (req.index == `DIO_IDX_SOFT_B)
        soft_b_q <= req.wdata & `DIO_SOFT_B_MASK;
    end
  end

  // Input one assignment; reserved middle bits dropped
  always_ff @(posedge mclk)
  begin
    if (srst)
      assign_q <= `DIO_RST_INPUT_ONE;
    else if (wr && req.index == `DIO_IDX_INPUT_ONE)
      assign_q <= req.wdata & `DIO_ASSIGN_MASK;
  end

  // Status mirrors internal outputs, not the pins
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      status_a_q <= '0;
      status_b_q <= '0;
    end
    else
    begin
      status_a_q <= {5'h00, drive_out_a};
      status_b_q <= {8'h00, drive_out_b};
    end
  end

  // Effective functions: connector, input one and software ORed
  always_ff @(posedge mclk)
  begin
    if (srst)
      eff_q <= '0;
    else if ((din_one_lvl ^ assign_q[`DIO_ASSIGN_POL_BIT])
             && assign_q[7:0] != `DIO_CODE_NONE)
      eff_q <= conn_lvl | {soft_b_q, soft_a_q}
               | code_to_func(assign_q[7:0]);
    else
      eff_q <= conn_lvl | {soft_b_q, soft_a_q};
  end

  // Magnitude of error; most negative value negates to itself, read unsigned as its magnitude
  assign err_abs = pos_err[ERR_W-1] ? ERR_W'(-pos_err) : ERR_W'(pos_err);
  assign in_band = err_abs < {{(ERR_W-16){1'b0}}, dead_band_q};

  always_ff @(posedge mclk)
  begin
    if (srst)
      pos_ctrl_out <= '0;
    else if (in_band)
      pos_ctrl_out <= '0;
    else
      pos_ctrl_out <= pos_ctrl_in;
  end

  // Access answer: one cycle later, unknown index, bad value or status write flags err
  always_ff @(posedge mclk)
  begin
    if (srst)
      rsp_q <= '0;
    else
    begin
      rsp_q.ack   <= req.valid;
      rsp_q.err   <= 1'b0;
      rsp_q.rdata <= 16'h0000;
      if (req.valid)
      begin
        unique case (req.index)
          `DIO_IDX_GAIN_WAIT:
          begin
            rsp_q.rdata <= gain_wait_q;
            rsp_q.err   <= req.write && !in_range;
          end
          `DIO_IDX_GAIN_RETURN:
          begin
            rsp_q.rdata <= gain_return_q;
            rsp_q.err   <= req.write && !in_range;
          end
          `DIO_IDX_DEAD_BAND:
          begin
            rsp_q.rdata <= dead_band_q;
            rsp_q.err   <= req.write && !in_range;
          end
          `DIO_IDX_SOFT_A:     rsp_q.rdata <= soft_a_q;
          `DIO_IDX_SOFT_B:     rsp_q.rdata <= soft_b_q;
          `DIO_IDX_STATUS_A:
          begin
            rsp_q.rdata <= status_a_q;
            rsp_q.err   <= req.write; // Read-only
          end
          `DIO_IDX_STATUS_B:
          begin
            rsp_q.rdata <= status_b_q;
            rsp_q.err   <= req.write; // Read-only
          end
          `DIO_IDX_INPUT_ONE:  rsp_q.rdata <= assign_q;
          default:             rsp_q.err   <= 1'b1;
        endcase
      end
    end
  end

  assign rsp            = rsp_q;
  assign eff_func       = eff_q;
  assign gain_wait_ms   = gain_wait_q;
  assign gain_return_ms = gain_return_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  AST_WAIT_RANGE: assert property (
    gain_wait_q <= `DIO_MAX_SETTING)
    else $error("gain wait time out of range");

  AST_RETURN_WRITE: assert property (
    (wr && in_range && req.index == `DIO_IDX_GAIN_RETURN)
    |=> gain_return_q == $past(req.wdata))
    else $error("return wait write not stored");

  AST_DEAD_BAND: assert property (
    in_band |=> pos_ctrl_out == '0)
    else $error("controller output not zero in dead band");

  AST_SOFT_OR: assert property (
    ##1 (eff_q & {$past(soft_b_q), $past(soft_a_q)})
    == {$past(soft_b_q), $past(soft_a_q)})
    else $error("software bit missing from function vector");

  AST_SOFT_A_RSVD: assert property (
    soft_a_q[9] == 1'b0)
    else $error("reserved control bit stored");

  AST_SOFT_B_WRITE: assert property (
    (wr && req.index == `DIO_IDX_SOFT_B) |=> soft_b_q == $past(req.wdata))
    else $error("control word B write lost");

  AST_STATUS_A: assert property (
    ##1 status_a_q == {5'h00, $past(drive_out_a)})
    else $error("status word A does not mirror outputs");

  AST_STATUS_B: assert property (
    ##1 status_b_q == {8'h00, $past(drive_out_b)})
    else $error("status word B does not mirror outputs");

  AST_SERVO_ON_PIN: assert property (
    (assign_q == `DIO_RST_INPUT_ONE && din_one_lvl) |=> eff_q.a[12])
    else $error("input one did not drive servo enable");

  AST_ASSIGN_RSVD: assert property (
    assign_q[14:8] == 7'h00)
    else $error("reserved assignment bits stored");

  AST_ACK: assert property (
    req.valid |=> rsp_q.ack ##1 (rsp_q.ack == $past(req.valid)))
    else $error("access answer timing wrong");

  COV_SOFT_WRITE: cover property (wr && req.index == `DIO_IDX_SOFT_A);
  COV_BAND_ZERO:  cover property (in_band && pos_ctrl_in != '0);
  COV_PIN_SERVO:  cover property (din_one_lvl ##1 eff_q.a[12]);
  COV_BAD_INDEX:  cover property (rsp_q.ack && rsp_q.err);

endmodule : dio_bank
`default_nettype wire

// file: dio_map.svh
// Summary of operation
// - A settable wait time is held for the change from gain group one to two.
// - A separate wait time for the change back, 0 to 1000 ms, reset 0, writable at any time.
// - The position controller output is forced to zero while the error is below the dead band.
// - Each input function is the OR of its connector input, its software control bit and input one where input one is assigned to it.
// - Control word A holds one function per bit; bit 9 is reserved.
// - Control word B holds sixteen further functions, one per bit, used the same way.
// - Status word A mirrors drive outputs in bits 10 to 0; bits 15 to 11 read zero.
// - Status word B mirrors origin, end of stroke and six index outputs; bits 15 to 8 read zero.
// - Status words follow the internal output states whether or not any pin carries them.
// - Input one has a 16-bit assignment word, writable at any time, reset to 0x000f.
// - Assignment bit 15 is polarity (1 inverts), bits 14 to 8 are reserved, bits 7 to 0 the code.
// - Assignment code 0x00 leaves the pin unused and 0x0f makes it drive servo enable.
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// Object indices
`define DIO_IDX_GAIN_WAIT      16'h211c
`define DIO_IDX_GAIN_RETURN    16'h211d
`define DIO_IDX_DEAD_BAND      16'h211e
`define DIO_IDX_SOFT_A         16'h211f
`define DIO_IDX_SOFT_B         16'h2120
`define DIO_IDX_STATUS_A       16'h2121
`define DIO_IDX_STATUS_B       16'h2122
`define DIO_IDX_INPUT_ONE      16'h2200

// Reset values
`define DIO_RST_GAIN_WAIT      16'h0000
`define DIO_RST_GAIN_RETURN    16'h0000
`define DIO_RST_DEAD_BAND      16'h0000
`define DIO_RST_SOFT           16'h0000
`define DIO_RST_INPUT_ONE      16'h000f

// Ranges and field layout
`define DIO_MAX_SETTING        16'h03e8
`define DIO_SOFT_A_MASK        16'hfdff
`define DIO_SOFT_B_MASK        16'hffff
`define DIO_ASSIGN_MASK        16'h80ff
`define DIO_ASSIGN_POL_BIT     15
`define DIO_CODE_NONE          8'h00
`define DIO_CODE_SERVO_ON      8'h0f
`define DIO_STAT_A_W           11
`define DIO_STAT_B_W           8

// Wait time unit: one millisecond at 20 MHz
`define DIO_CLK_HZ             20000000
`define DIO_WAIT_UNIT_MS       1
`define DIO_CYC_PER_MS         (`DIO_CLK_HZ / 1000 * `DIO_WAIT_UNIT_MS)

`endif

// file: dio_pkg.sv
`default_nettype none
package dio_pkg;

  // Parameter access request from the fieldbus side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [15:0] wdata;
  } dio_req_t;

  // Answer, one cycle after the request
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } dio_rsp_t;

  // Input function vector: word A in low half, word B in high half
  typedef struct packed {
    logic [15:0] b;
    logic [15:0] a;
  } dio_func_t;

endpackage : dio_pkg
`default_nettype wire

// file: dio_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dio_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // Three stages; first stage feeds only the second
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-bit agreement of stages two and three
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      assign agree[i] = (s2_q[i] == s3_q[i]);
    end
  endgenerate

  // One process owns the output; a bit moves only while its stages agree
  always_ff @(posedge mclk)
  begin
    if (srst)
      level <= '0;
    else
      level <= (level & ~agree) | (s3_q & agree);
  end

endmodule : dio_pin_sync
`default_nettype wire

// file: dio_master.sv
`timescale 1ns/10ps
`default_nettype none
module dio_master
  import dio_pkg::*;
(
  input  wire logic     mclk,
  output var dio_req_t  req,
  input  wire dio_rsp_t rsp
);
  // Idle request
  initial req = '0;

  // One request pulse; answer stands only one cycle, so take it before
  // release. Released fields show inverted values, not stale ones.
  task automatic xfer(input logic wr, input logic [15:0] idx,
                      input logic [15:0] wd, output logic [15:0] rd,
                      output logic er, output logic ak);
    @(negedge mclk);
    req <= '{1'b1, wr, idx, wd};
    @(negedge mclk);
    rd = rsp.rdata;
    er = rsp.err;
    ak = rsp.ack;
    req <= '{1'b0, 1'b0, ~idx, ~wd};
  endtask : xfer
endmodule : dio_master
`default_nettype wire

// file: drive_io_override_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module drive_io_override_bank_tb_top
  import dio_pkg::*;
;
  logic               mclk;
  logic               srst;
  dio_req_t           req;
  dio_rsp_t           rsp;
  logic               din;
  logic [31:0]        conn;
  logic [10:0]        dra;
  logic [7:0]         drb;
  logic signed [31:0] perr;
  logic signed [31:0] pin_c;
  logic signed [31:0] pout;
  dio_func_t          eff;
  logic [15:0]        gw;
  logic [15:0]        gr;
  logic [15:0]        mdl[int];
  logic [31:0]        seed = 32'h1d65;
  logic [31:0]        w;
  int                 n_mismatch = 0;
  int                 checked = 0;
  int                 cyc = 0;
  logic [15:0]        codes[9] = '{16'h0001, 16'h000b, 16'h0023,
                                   16'h0010, 16'h001f, 16'h0022,
                                   16'h0009, 16'h800f, 16'hffff};

  dio_bank i_dut (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp),
    .din_one_pin(din), .conn_func_pin(conn), .drive_out_a(dra),
    .drive_out_b(drb), .pos_err(perr), .pos_ctrl_in(pin_c),
    .pos_ctrl_out(pout), .eff_func(eff), .gain_wait_ms(gw),
    .gain_return_ms(gr));
  dio_master i_mst (.mclk(mclk), .req(req), .rsp(rsp));

  // Free-running 20 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  function automatic logic [31:0] rnd();
    seed = {1'b0, seed[31:1]} ^ (seed[0] ? 32'h80200003 : 32'h0);
    return seed;
  endfunction : rnd

  // Expected function vector; code table mirrors the chosen assignment map
  function automatic logic [31:0] fexp(input logic [31:0] c,
                                       input logic p);
    logic [31:0] e;
    logic [7:0]  k;
    e = c | {mdl[16'h2120], mdl[16'h211f]};
    k = mdl[16'h2200][7:0];
    if (p ^ mdl[16'h2200][15])
    begin
      if (k inside {[8'h01:8'h08], 8'h0b, 8'h0c}) e[k - 8'h01] = 1'b1;
      if (k == 8'h0f) e[12] = 1'b1;
      if (k inside {[8'h10:8'h1f]}) e[k] = 1'b1;
      if (k inside {[8'h20:8'h22]}) e[k - 8'h13] = 1'b1;
      if (k == 8'h23) e[8] = 1'b1;
    end
    return e;
  endfunction : fexp

  // Model decides refusal and old value before the bus access
  task automatic acc(input logic wr, input logic [15:0] idx,
                     input logic [15:0] wd);
    logic [15:0] rd;
    logic [15:0] ev;
    logic [15:0] m;
    logic        er;
    logic        ak;
    logic        ee;
    ee = !mdl.exists(idx);
    if (wr && (idx inside {16'h2121, 16'h2122})) ee = 1'b1;
    if (wr && idx < 16'h211f && wd > 16'h03e8) ee = 1'b1;
    ev = ee ? 16'h0 : mdl[idx];
    m = (idx == 16'h211f) ? 16'hfdff : 16'hffff;
    if (idx == 16'h2200) m = 16'h80ff;
    if (wr && !ee) mdl[idx] = wd & m;
    i_mst.xfer(wr, idx, wd, rd, er, ak);
    check(ak, 1'b1);
    check(er, ee);
    if (!ee) check(rd, ev);
  endtask : acc

  // Hang guard, well above the two hundred or so cycles needed
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    srst = 1'b1;
    din = 1'b0;
    conn = '0;
    dra = '0;
    drb = '0;
    perr = '0;
    pin_c = '0;
    for (int i = 16'h211c; i <= 16'h2122; i++) mdl[i] = 16'h0;
    mdl[16'h2200] = 16'h000f;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    foreach (mdl[i]) acc(1'b0, i[15:0], 16'h0);
    acc(1'b1, 16'h211c, 16'h03e8);
    acc(1'b1, 16'h211d, 16'h03e8);
    acc(1'b1, 16'h211d, 16'h03e9);
    acc(1'b1, 16'h211e, 16'h03e9);
    check(gw, mdl[16'h211c]);
    check(gr, mdl[16'h211d]);
    // Soft words ORed with connector levels
    for (int i = 0; i < 4; i++)
    begin
      conn = rnd();
      w = rnd();
      acc(1'b1, 16'h211f, w[15:0]);
      acc(1'b1, 16'h2120, w[31:16]);
      acc(1'b0, 16'h211f, 16'h0);
      repeat (6) @(negedge mclk);
      check(eff, fexp(conn, din));
      din = ~din;
    end
    // Assignment codes and polarity with the pin held high
    conn = '0;
    din = 1'b1;
    acc(1'b1, 16'h211f, 16'h0);
    acc(1'b1, 16'h2120, 16'h0);
    repeat (6) @(negedge mclk);
    for (int i = 0; i < 9; i++)
    begin
      acc(1'b1, 16'h2200, codes[i]);
      repeat (2) @(negedge mclk);
      check(eff, fexp(conn, din));
    end
    acc(1'b0, 16'h2200, 16'h0);
    // Status mirrors drive outputs, reserved bits zero
    for (int i = 0; i < 4; i++)
    begin
      w = rnd();
      dra = w[10:0];
      drb = w[23:16];
      mdl[16'h2121] = {5'h0, w[10:0]};
      mdl[16'h2122] = {8'h0, w[23:16]};
      @(negedge mclk);
      acc(1'b0, 16'h2121, 16'h0);
      acc(1'b0, 16'h2122, 16'h0);
    end
    acc(1'b1, 16'h2121, 16'hffff);
    acc(1'b0, 16'h2123, 16'h0);
    // Dead band boundaries at plus and minus five
    acc(1'b1, 16'h211e, 16'h0005);
    for (int i = -6; i <= 6; i++)
    begin
      w = rnd();
      perr = i;
      pin_c = w;
      @(negedge mclk);
      check(pout, (i < 5 && i > -5) ? 32'h0 : w);
    end
    finish_test();
  end
endmodule : drive_io_override_bank_tb_top
`default_nettype wire
